/* common/imsn_ctl_if.sv */
`timescale 1ns/100ps
// ****************************************
// host access to one 8-level controller
// ****************************************
interface imsn_ctl_if;
    logic cmd_wr;
    logic mask_wr;
    logic cmd_rd;
    logic [7:0] wdata;
    logic inta;
    logic [7:0] req;
    logic [7:0] mask;
    logic [7:0] status;
    logic int_req;
    logic [2:0] vec_level;
    modport ctl(input cmd_wr, mask_wr, cmd_rd, wdata, inta, req, output mask, status, int_req, vec_level);
    modport top(output cmd_wr, mask_wr, cmd_rd, wdata, inta, req, input mask, status, int_req, vec_level);
endinterface

/* common/imsn_defs.svh */
`ifndef IMSN_DEFS_SVH
`define IMSN_DEFS_SVH

// ****************************************
// i/o port addresses
// ****************************************
`define IMSN_ADDR_MCTL_CMD 16'h0020
`define IMSN_ADDR_MCTL_MASK 16'h0021
`define IMSN_ADDR_SCTL_CMD 16'h00A0
`define IMSN_ADDR_SCTL_MASK 16'h00A1
`define IMSN_ADDR_NMI_STATUS 16'h0061
`define IMSN_ADDR_NMI_ENABLE 16'h0070
`define IMSN_ADDR_NMI_EXT 16'h0461
`define IMSN_ADDR_NMI_SWTRIG 16'h0462

// ****************************************
// operation word three fields
// ****************************************
`define IMSN_OW3_SEL_BIT 3
`define IMSN_OW3_SEL_VAL 2'h1
`define IMSN_OW3_SPECIAL_MASK_SET_ENABLE 6
`define IMSN_OW3_SMM 5
`define IMSN_OW3_POLL 2
`define IMSN_OW3_RR 1
`define IMSN_OW3_RIS 0
// operation word two: end of interrupt and specific level
`define IMSN_OW2_EOI 5
`define IMSN_OW2_SL 6

// ****************************************
// nmi port bit positions
// ****************************************
`define IMSN_ST_PERR 7
`define IMSN_ST_IOCHK 6
`define IMSN_EN_PERR 2
`define IMSN_EN_IOCHK 3
`define IMSN_EX_FSAFE 7
`define IMSN_EX_BTO 6
`define IMSN_EX_SWNMI 5
`define IMSN_EN_FSAFE 2
`define IMSN_EN_BTO 3
`define IMSN_EN_SWNMI 1
`define IMSN_GLOBAL_DIS 7

// ****************************************
// reset values and timeouts
// ****************************************
`define IMSN_MASK_RESET 8'hFF
`define IMSN_PREEMPT_LIMIT 64
`define IMSN_CMD_LIMIT 256

`endif

/* common/imsn_pkg.sv */
package imsn_pkg;
    typedef logic [7:0] imsn_byte_t;
    typedef enum logic {IMSN_SEL_PENDING, IMSN_SEL_SERVICE} imsn_sel_e;
endpackage

/* verif/imsn_host_model.sv */
`timescale 1ns/100ps
module imsn_host_model (
    // clock
    input wire logic sys_clk_in,
    // i/o port access
    output logic [15:0] io_addr_out,
    output logic io_wr_out,
    output logic io_rd_out,
    output logic [7:0] io_wdata_out,
    input wire logic [7:0] io_rdata_in
);
    initial begin
        io_addr_out = 16'h0000;
        io_wr_out = 1'b0;
        io_rd_out = 1'b0;
        io_wdata_out = 8'h00;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        io_addr_out <= a;
        io_wdata_out <= d;
        io_wr_out <= 1'b1;
        @(posedge sys_clk_in);
        io_wr_out <= 1'b0;
        // released data must not look like the last value
        io_wdata_out <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        io_addr_out <= a;
        io_rd_out <= 1'b1;
        @(posedge sys_clk_in);
        io_rd_out <= 1'b0;
        #1;
        d = io_rdata_in;
    endtask
    // lets the nmi output fall and rise again for any pending source
    task automatic rearm();
        wr(16'h0070, 8'h80);
        wr(16'h0070, 8'h00);
    endtask
endmodule // imsn_host_model

/* verif/imsn_top_chk.sv */
`timescale 1ns/100ps
module imsn_top_chk #(
    parameter int PREEMPT_LIMIT = 64,
    parameter int CMD_LIMIT = 256
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic srst_in,
    // watched pins
    input wire logic [15:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic [7:0] io_wdata_in,
    input wire logic [7:0] io_rdata_out,
    input wire logic mreq_n_in,
    input wire logic cmd_n_in,
    input wire logic nmi_out,
    input wire logic expansion_reset_drive_out
);
    // ****************************************
    // shadow of host controls
    // ****************************************
    logic gdis;
    logic [4:0] ens;
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) gdis <= 1'b1;
        else if (io_wr_in && io_addr_in == 16'h0070) gdis <= io_wdata_in[7];
    end
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) ens <= 5'h00;
        else if (io_wr_in && io_addr_in == 16'h0061) ens[1:0] <= io_wdata_in[3:2];
        else if (io_wr_in && io_addr_in == 16'h0461) ens[4:2] <= io_wdata_in[3:1];
    end
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (srst_in);
    sequence s_wr_rd(a);
        io_wr_in && io_addr_in == a ##1 !io_wr_in && io_addr_in == a;
    endsequence
    property p_mask_rd;
        s_wr_rd(16'h0021) |=> io_rdata_out == $past(io_wdata_in, 2);
    endproperty
    a_mask_rd: assert property (p_mask_rd) else $error("master mask readback wrong");
    property p_smask_rd;
        s_wr_rd(16'h00A1) |=> io_rdata_out == $past(io_wdata_in, 2);
    endproperty
    a_smask_rd: assert property (p_smask_rd) else $error("slave mask readback wrong");
    property p_src_en_rd;
        s_wr_rd(16'h0061) |=> ((io_rdata_out ^ $past(io_wdata_in, 2)) & 8'h0C) == 8'h00;
    endproperty
    a_src_en_rd: assert property (p_src_en_rd) else $error("status port enables wrong");
    property p_ext_en_rd;
        s_wr_rd(16'h0461) |=> ((io_rdata_out ^ $past(io_wdata_in, 2)) & 8'h0E) == 8'h00;
    endproperty
    a_ext_en_rd: assert property (p_ext_en_rd) else $error("extended enables wrong");
    property p_gdis_rd;
        s_wr_rd(16'h0070) |=> io_rdata_out[7] == gdis;
    endproperty
    a_gdis_rd: assert property (p_gdis_rd) else $error("global disable readback wrong");
    property p_gate;
        gdis ##1 gdis |=> !nmi_out;
    endproperty
    a_gate: assert property (p_gate) else $error("nmi while globally disabled");
    property p_no_en;
        ens == 5'h00 ##1 ens == 5'h00 |=> !nmi_out;
    endproperty
    a_no_en: assert property (p_no_en) else $error("nmi with no source enabled");
    property p_expansion_reset_drive_idle;
        (cmd_n_in && mreq_n_in) [*8] |-> !expansion_reset_drive_out;
    endproperty
    a_expansion_reset_drive_idle: assert property (p_expansion_reset_drive_idle) else $error("reset drive without timeout");
endmodule // imsn_top_chk

/* verif/irq_mask_status_and_nmi_logic_tb_top.sv */
`timescale 1ns/100ps
module irq_mask_status_and_nmi_logic_tb_top;
    logic sys_clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic [15:0] io_addr_in;
    logic io_wr_in, io_rd_in;
    logic [7:0] io_wdata_in, io_rdata_out;
    logic inta_in = 1'b0;
    logic [15:0] irq_in = 16'h0000;
    logic intr_out, nmi_out, expansion_reset_drive_out;
    logic [3:0] intr_level_out;
    logic perr_n_in = 1'b1, serr_n_in = 1'b1, iochk_n_in = 1'b1, failsafe_in = 1'b0;
    logic bclk_in = 1'b0, mreq_n_in = 1'b1, mack_n_in = 1'b1, cmd_n_in = 1'b1;
    logic chrdy_in = 1'b0, dma_cycle_in = 1'b0;
    logic bclk_div = 1'b0;
    int error_cnt = 0, num_checks = 0, cyc = 0;
    always #20 sys_clk_in = ~sys_clk_in;
    // each bus clock level lasts two cycles, so the pin filter can agree on it
    always @(posedge sys_clk_in) {bclk_in, bclk_div} <= {bclk_in, bclk_div} + 2'h1;
    imsn_top #(.PREEMPT_LIMIT(4), .CMD_LIMIT(8)) u_dut (.sys_clk_in, .srst_in, .io_addr_in, .io_wr_in,
        .io_rd_in, .io_wdata_in, .io_rdata_out, .inta_in, .irq_in, .intr_out, .intr_level_out, .perr_n_in,
        .serr_n_in, .iochk_n_in, .failsafe_in, .bclk_in, .mreq_n_in, .mack_n_in, .cmd_n_in, .chrdy_in,
        .dma_cycle_in, .nmi_out, .expansion_reset_drive_out);
    imsn_host_model u_host (.sys_clk_in, .io_addr_out(io_addr_in), .io_wr_out(io_wr_in),
        .io_rd_out(io_rd_in), .io_wdata_out(io_wdata_in), .io_rdata_in(io_rdata_out));
    // ****************************************
    // checking helpers
    // ****************************************
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        num_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic rm(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
        logic [7:0] d;
        u_host.rd(a, d);
        chk(d & m, e);
    endtask
    task automatic fl(input logic f, input logic e);
        chk({7'h00, f}, {7'h00, e});
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask
    task automatic w(input logic [15:0] a, input logic [7:0] d);
        u_host.wr(a, d);
    endtask
    // hang guard, run needs well under a thousand cycles
    always @(posedge sys_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            error_cnt++;
            summarize();
        end
    end
    // ****************************************
    // test sequence
    // ****************************************
    initial begin
        repeat (2) @(posedge sys_clk_in);
        srst_in <= 1'b0;
        rm(16'h0021, 8'hFF, 8'hFF);
        rm(16'h0300, 8'hFF, 8'h00);
        w(16'h0021, 8'h00);
        w(16'h00A1, 8'h00);
        irq_in <= 16'h0008;
        rm(16'h0020, 8'hFF, 8'h08);
        w(16'h0021, 8'h08);
        idle(1);
        fl(intr_out, 1'b0);
        rm(16'h0020, 8'hFF, 8'h08);
        w(16'h0021, 8'h00);
        idle(1);
        chk({4'h0, intr_level_out}, 8'h03);
        inta_in <= 1'b1;
        @(posedge sys_clk_in) inta_in <= 1'b0;
        w(16'h0020, 8'h0A);
        rm(16'h0020, 8'hFF, 8'h00);
        w(16'h0020, 8'h0B);
        rm(16'h0020, 8'hFF, 8'h08);
        rm(16'h0020, 8'hFF, 8'h08);
        irq_in <= 16'h0028;
        idle(3);
        fl(intr_out, 1'b0);
        w(16'h0020, 8'h68);
        idle(1);
        chk({3'h0, intr_out, intr_level_out}, 8'h15);
        w(16'h0020, 8'h48);
        idle(1);
        fl(intr_out, 1'b0);
        w(16'h0020, 8'h20);
        rm(16'h0020, 8'hFF, 8'h00);
        w(16'h0020, 8'h0E);
        rm(16'h0020, 8'hFF, 8'h85);
        w(16'h0020, 8'h20);
        irq_in <= 16'h0228;
        w(16'h0021, 8'h04);
        idle(3);
        fl(intr_out, 1'b0);
        w(16'h0021, 8'h00);
        idle(1);
        chk({3'h0, intr_out, intr_level_out}, 8'h19);
        w(16'h0070, 8'h00);
        for (int i = 0; i < 3; i++) begin
            w(16'h0061, i == 2 ? 8'h08 : 8'h04);
            perr_n_in <= i != 0;
            serr_n_in <= i != 1;
            iochk_n_in <= i != 2;
            idle(8);
            perr_n_in <= 1'b1;
            serr_n_in <= 1'b1;
            iochk_n_in <= 1'b1;
            fl(nmi_out, 1'b1);
            rm(16'h0061, 8'hC0, i == 2 ? 8'h40 : 8'h80);
            w(16'h0070, 8'h80);
            idle(1);
            fl(nmi_out, 1'b0);
            rm(16'h0061, 8'hC0, i == 2 ? 8'h40 : 8'h80);
            w(16'h0070, 8'h00);
            idle(1);
            fl(nmi_out, 1'b1);
            w(16'h0061, 8'h00);
            rm(16'h0061, 8'hC0, 8'h00);
        end
        for (int i = 0; i < 2; i++) begin
            w(16'h0461, i ? 8'h02 : 8'h04);
            failsafe_in <= i == 0;
            if (i) w(16'h0462, 8'h5A);
            idle(8);
            failsafe_in <= 1'b0;
            u_host.rearm();
            idle(1);
            fl(nmi_out, 1'b1);
            rm(16'h0461, 8'hE0, i ? 8'h20 : 8'h80);
            w(16'h0461, 8'h00);
        end
        w(16'h0461, 8'h08);
        mreq_n_in <= 1'b0;
        idle(30);
        fl(expansion_reset_drive_out, 1'b1);
        rm(16'h0461, 8'h40, 8'h40);
        mreq_n_in <= 1'b1;
        // let the filtered pin and the counter settle before re-arming the detect
        idle(8);
        w(16'h0461, 8'h00);
        w(16'h0461, 8'h08);
        cmd_n_in <= 1'b0;
        dma_cycle_in <= 1'b1;
        idle(40);
        fl(expansion_reset_drive_out, 1'b0);
        rm(16'h0461, 8'h40, 8'h00);
        dma_cycle_in <= 1'b0;
        idle(60);
        fl(expansion_reset_drive_out, 1'b1);
        cmd_n_in <= 1'b1;
        summarize();
    end
endmodule // irq_mask_status_and_nmi_logic_tb_top
bind imsn_top imsn_top_chk #(.PREEMPT_LIMIT(PREEMPT_LIMIT), .CMD_LIMIT(CMD_LIMIT)) u_chk (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .io_addr_in(io_addr_in), .io_wr_in(io_wr_in),
    .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out), .mreq_n_in(mreq_n_in), .cmd_n_in(cmd_n_in),
    .nmi_out(nmi_out), .expansion_reset_drive_out(expansion_reset_drive_out));

/* verilog/imsn_ctl.sv */
`timescale 1ns/100ps
`include "imsn_defs.svh"
module imsn_ctl (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic srst_in,
    // host side
    imsn_ctl_if.ctl bus
);
    imsn_pkg::imsn_byte_t pending;
    imsn_pkg::imsn_byte_t in_service;
    imsn_pkg::imsn_byte_t mask;
    imsn_pkg::imsn_byte_t req_q;
    imsn_pkg::imsn_sel_e rd_sel;
    logic special_mask;
    logic poll_armed;

    // lowest set bit wins: level 0 is highest priority
    function automatic logic [7:0] imsn_lowest(input logic [7:0] v);
        return v & (~v + 8'h01);
    endfunction

    function automatic logic [2:0] imsn_enc(input logic [7:0] onehot);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (onehot[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction

    logic [7:0] eligible;
    logic [7:0] top_req;
    logic [7:0] top_isr;
    logic [7:0] blocked;
    logic ack_evt;

    always_comb begin
        top_isr = imsn_lowest(in_service);
        blocked = 8'h00;
        // lower priority levels are held off behind the active one
        for (int i = 0; i < 8; i++) begin
            if (top_isr[i]) begin
                blocked = ~(top_isr - 8'h01); // [RL5]
            end
        end
        if (special_mask) begin
            blocked = in_service & mask; // [RL3]
        end
        eligible = pending & ~mask & ~blocked; // [RL1]
        top_req = imsn_lowest(eligible);
    end

    assign ack_evt = bus.inta | (bus.cmd_rd & poll_armed);

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            mask <= `IMSN_MASK_RESET;
        end else if (bus.mask_wr) begin
            mask <= bus.wdata;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            req_q <= 8'h00;
            pending <= 8'h00;
        end else begin
            req_q <= bus.req;
            // edge latch independent of mask; set wins over ack clear
            pending <= (pending & ~(ack_evt ? top_req : 8'h00)) | (bus.req & ~req_q); // [RL6]
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            in_service <= 8'h00;
        end else if (ack_evt) begin
            in_service <= in_service | top_req;
        end else if (bus.cmd_wr && bus.wdata[4:3] == 2'h0 && bus.wdata[`IMSN_OW2_EOI]) begin
            if (bus.wdata[`IMSN_OW2_SL]) begin
                in_service <= in_service & ~(8'h01 << bus.wdata[2:0]); // [RL7]
            end else begin
                in_service <= in_service & ~top_isr; // [RL7]
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            rd_sel <= imsn_pkg::IMSN_SEL_PENDING; // [RL11]
            special_mask <= 1'b0;
            poll_armed <= 1'b0;
        end else if (bus.cmd_wr && bus.wdata[4:3] == `IMSN_OW3_SEL_VAL) begin
            if (bus.wdata[`IMSN_OW3_SPECIAL_MASK_SET_ENABLE]) begin
                special_mask <= bus.wdata[`IMSN_OW3_SMM]; // [RL4]
            end
            if (bus.wdata[`IMSN_OW3_RR]) begin
                rd_sel <= bus.wdata[`IMSN_OW3_RIS] ? imsn_pkg::IMSN_SEL_SERVICE : imsn_pkg::IMSN_SEL_PENDING; // [RL8]
            end
            poll_armed <= bus.wdata[`IMSN_OW3_POLL];
        end else if (bus.cmd_rd) begin
            poll_armed <= 1'b0; // selection itself persists [RL9]
        end
    end

    always_comb begin
        if (poll_armed) begin
            bus.status = {|eligible, 4'h0, imsn_enc(top_req)}; // [RL10]
        end else if (rd_sel == imsn_pkg::IMSN_SEL_SERVICE) begin
            bus.status = in_service;
        end else begin
            bus.status = pending;
        end
    end

    assign bus.mask = mask;
    assign bus.int_req = |eligible;
    assign bus.vec_level = imsn_enc(top_req);
endmodule // imsn_ctl

/* verilog/imsn_top.sv */
`timescale 1ns/100ps
`include "imsn_defs.svh"
// Functional notes
// RL1: set mask bit blocks its own channel
// RL2: master level 2 mask blocks whole slave
// RL3: special mask: only masked levels inhibited
// RL4: special_mask_set_enable=1 smm selects special mask mode
// RL5: in-service level blocks lower priorities normally
// RL6: pending register, top bit cleared on acknowledge
// RL7: in-service register updated by end-of-interrupt
// RL8: rr/ris choose pending or in-service read
// RL9: read selection persists across status reads
// RL10: poll response overrides status read
// RL11: selection defaults to pending after init
// RL12: mask address read returns mask
// RL13: nmi latches parity, serr, iochk, failsafe, timeout
// RL14: preempted master over 64 bclk times out; the code times out at the 64th bclk rise, not after it
// RL15: cmd over 256 bclk times out, not dma
// RL16: bus timeout drives expansion reset
// RL17: any write to trigger port raises nmi
// RL18: status port bits 7,6; enables 2,3
// RL19: extended port bits 7,6,5; enables 2,3,1
// RL20: clearing enable clears detect flip-flop
// RL21: global disable gates without clearing detects
// RL22: host toggles global disable to re-edge nmi
// RL23: nmi is or of enabled detects, gated
module imsn_top #(
    parameter int PREEMPT_LIMIT = `IMSN_PREEMPT_LIMIT,
    parameter int CMD_LIMIT = `IMSN_CMD_LIMIT
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic srst_in,
    // i/o port access
    input wire logic [15:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out,
    input wire logic inta_in,
    // interrupt requests, 15:8 on the slave controller
    input wire logic [15:0] irq_in,
    output logic intr_out,
    output logic [3:0] intr_level_out,
    // error sources, active low pins except failsafe_in, which is active high
    input wire logic perr_n_in,
    input wire logic serr_n_in,
    input wire logic iochk_n_in,
    input wire logic failsafe_in,
    // expansion bus monitors, sampled each sys_clk_in cycle
    input wire logic bclk_in,
    input wire logic mreq_n_in,
    input wire logic mack_n_in,
    input wire logic cmd_n_in,
    input wire logic chrdy_in,
    input wire logic dma_cycle_in,
    // nmi and reset drive
    output logic nmi_out,
    output logic expansion_reset_drive_out
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    localparam int NSYNC = 10;
    logic [NSYNC-1:0] pins_raw;
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    logic [NSYNC-1:0] pins;
    assign pins_raw = {~perr_n_in, ~serr_n_in, ~iochk_n_in, failsafe_in, bclk_in,
                       ~mreq_n_in, ~mack_n_in, ~cmd_n_in, chrdy_in, dma_cycle_in};

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            pins <= '0;
        end else begin
            s1 <= pins_raw;
            s2 <= s1;
            s3 <= s2;
            // change accepted once stages two and three agree
            for (int i = 0; i < NSYNC; i++) begin
                if (s2[i] == s3[i]) begin
                    pins[i] <= s3[i];
                end
            end
        end
    end

    logic perr_a, serr_a, iochk_a, fsafe_a, bclk_s, mreq_a, mack_a, cmd_a, chrdy_s, dma_s;
    assign {perr_a, serr_a, iochk_a, fsafe_a, bclk_s, mreq_a, mack_a, cmd_a, chrdy_s, dma_s} = pins;

    // ****************************************
    // cascaded interrupt controllers
    // ****************************************
    imsn_ctl_if m_if();
    imsn_ctl_if s_if();
    logic slave_sel;

    assign m_if.cmd_wr = io_wr_in && io_addr_in == `IMSN_ADDR_MCTL_CMD;
    assign m_if.mask_wr = io_wr_in && io_addr_in == `IMSN_ADDR_MCTL_MASK;
    assign m_if.cmd_rd = io_rd_in && io_addr_in == `IMSN_ADDR_MCTL_CMD;
    assign m_if.wdata = io_wdata_in;
    assign m_if.inta = inta_in;
    // slave output feeds master level 2; its mask bit hides the slave [RL2]
    assign m_if.req = {irq_in[7:3], s_if.int_req, irq_in[1:0]};

    assign s_if.cmd_wr = io_wr_in && io_addr_in == `IMSN_ADDR_SCTL_CMD;
    assign s_if.mask_wr = io_wr_in && io_addr_in == `IMSN_ADDR_SCTL_MASK;
    assign s_if.cmd_rd = io_rd_in && io_addr_in == `IMSN_ADDR_SCTL_CMD;
    assign s_if.wdata = io_wdata_in;
    assign slave_sel = m_if.vec_level == 3'h2;
    assign s_if.inta = inta_in && slave_sel;
    assign s_if.req = irq_in[15:8];

    imsn_ctl u_master (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .bus(m_if)
    );
    imsn_ctl u_slave (
        .sys_clk_in(sys_clk_in),
        .srst_in(srst_in),
        .bus(s_if)
    );

    assign intr_out = m_if.int_req;
    assign intr_level_out = slave_sel ? {1'b1, s_if.vec_level} : {1'b0, m_if.vec_level};

    // ****************************************
    // expansion bus timeout monitors
    // ****************************************
    logic bclk_d;
    logic bclk_rise;
    logic [8:0] preempt_cnt;
    logic [8:0] cmd_cnt;
    logic bus_timeout_evt;

    assign bclk_rise = bclk_s & ~bclk_d;

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            bclk_d <= 1'b0;
            preempt_cnt <= 9'h000;
            cmd_cnt <= 9'h000;
        end else begin
            bclk_d <= bclk_s;
            if (!(mreq_a && !mack_a)) begin
                preempt_cnt <= 9'h000;
            end else if (bclk_rise && preempt_cnt < 9'(PREEMPT_LIMIT)) begin
                preempt_cnt <= preempt_cnt + 9'h001; // [RL14]
            end
            if (!cmd_a || dma_s) begin
                cmd_cnt <= 9'h000; // [RL15]
            end else if (bclk_rise && !chrdy_s && cmd_cnt <= 9'(CMD_LIMIT)) begin
                cmd_cnt <= cmd_cnt + 9'h001; // [RL15]
            end
        end
    end

    assign bus_timeout_evt = preempt_cnt == 9'(PREEMPT_LIMIT) || cmd_cnt > 9'(CMD_LIMIT);

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            expansion_reset_drive_out <= 1'b0;
        end else begin
            expansion_reset_drive_out <= bus_timeout_evt; // [RL16]
        end
    end

    // ****************************************
    // nmi enables and detect flip-flops
    // ****************************************
    logic wr_status, wr_enable, wr_ext, wr_sw;
    logic en_perr, en_iochk, en_fsafe, en_bto, en_sw, glb_dis;
    logic det_perr, det_iochk, det_fsafe, det_bto, det_sw;
    logic [3:0] st_low;
    logic [1:0] ext_low;

    assign wr_status = io_wr_in && io_addr_in == `IMSN_ADDR_NMI_STATUS;
    assign wr_enable = io_wr_in && io_addr_in == `IMSN_ADDR_NMI_ENABLE;
    assign wr_ext = io_wr_in && io_addr_in == `IMSN_ADDR_NMI_EXT;
    assign wr_sw = io_wr_in && io_addr_in == `IMSN_ADDR_NMI_SWTRIG; // [RL17]

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            en_perr <= 1'b0;
            en_iochk <= 1'b0;
            st_low <= 4'h0;
        end else if (wr_status) begin
            en_perr <= io_wdata_in[`IMSN_EN_PERR]; // [RL18]
            en_iochk <= io_wdata_in[`IMSN_EN_IOCHK]; // [RL18]
            st_low <= {io_wdata_in[5:4], io_wdata_in[1:0]};
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            en_fsafe <= 1'b0;
            en_bto <= 1'b0;
            en_sw <= 1'b0;
            ext_low <= 2'h0;
        end else if (wr_ext) begin
            en_fsafe <= io_wdata_in[`IMSN_EN_FSAFE]; // [RL19]
            en_bto <= io_wdata_in[`IMSN_EN_BTO]; // [RL19]
            en_sw <= io_wdata_in[`IMSN_EN_SWNMI]; // [RL19]
            ext_low <= {io_wdata_in[4], io_wdata_in[0]};
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            glb_dis <= 1'b1;
        end else if (wr_enable) begin
            glb_dis <= io_wdata_in[`IMSN_GLOBAL_DIS]; // [RL21]
        end
    end

    // detects follow the enable as it stands; a disabled enable holds the flop clear
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            det_perr <= 1'b0;
            det_iochk <= 1'b0;
            det_fsafe <= 1'b0;
            det_bto <= 1'b0;
            det_sw <= 1'b0;
        end else begin
            det_perr <= en_perr & (det_perr | perr_a | serr_a); // [RL13] [RL20]
            det_iochk <= en_iochk & (det_iochk | iochk_a); // [RL13] [RL20]
            det_fsafe <= en_fsafe & (det_fsafe | fsafe_a); // [RL13] [RL20]
            det_bto <= en_bto & (det_bto | bus_timeout_evt); // [RL13] [RL20]
            det_sw <= en_sw & (det_sw | wr_sw); // [RL20]
        end
    end

    // global disable gates only the output, detects survive [RL21]
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            nmi_out <= 1'b0;
        end else begin
            nmi_out <= ~glb_dis & (det_perr | det_iochk | det_fsafe | det_bto | det_sw); // [RL23]
        end
    end

    // ****************************************
    // read data
    // ****************************************
    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            io_rdata_out <= 8'h00;
        end else begin
            unique case (io_addr_in)
                `IMSN_ADDR_MCTL_MASK: io_rdata_out <= m_if.mask; // [RL12]
                `IMSN_ADDR_SCTL_MASK: io_rdata_out <= s_if.mask;
                `IMSN_ADDR_MCTL_CMD: io_rdata_out <= m_if.status;
                `IMSN_ADDR_SCTL_CMD: io_rdata_out <= s_if.status;
                `IMSN_ADDR_NMI_STATUS: io_rdata_out <= {det_perr, det_iochk, st_low[3:2], en_iochk, en_perr,
                                                         st_low[1:0]}; // [RL18]
                `IMSN_ADDR_NMI_EXT: io_rdata_out <= {det_fsafe, det_bto, det_sw, ext_low[1], en_bto, en_fsafe,
                                                      en_sw, ext_low[0]}; // [RL19]
                `IMSN_ADDR_NMI_ENABLE: io_rdata_out <= {glb_dis, 7'h00};
                default: io_rdata_out <= 8'h00;
            endcase
        end
    end
endmodule // imsn_top
